//--- testbench/tb.sv
// Self-checking bench for the translation block
`default_nettype none
module tb import vat_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic        mclk_in = 0, rst_b_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0;
    logic        req_valid_in = 0, thread_enter_in = 0, thread_leave_in = 0, err;
    logic        pready_out, pslverr_out, req_ready_out, rsp_valid_out, exception_out;
    logic        thread_granted_out, mem_req_out, mem_ack_in;
    logic [11:0] paddr_in = '0;
    logic [31:0] pwdata_in = '0, prdata_out, mem_rdata_in, r;
    core_req_t   req_in = '0;
    core_rsp_t   rsp_out;
    mem_req_t    mem_out;
    int          failures = 0, checks_done = 0, cyc = 0;
    virtual_address_translation virtual_address_translation_inst (.*);
    vat_mem_model vat_mem_model_inst (.mclk_in, .mem_req_in(mem_req_out), .mem_in(mem_out),
        .mem_ack_out(mem_ack_in), .mem_rdata_out(mem_rdata_in));
    initial forever #2.5 mclk_in = ~mclk_in;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge mclk_in);
        penable_in <= 1'b1;
        do @(posedge mclk_in); while (pready_out !== 1'b1);
        r = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(r, e);
    endtask
    task automatic xlate(input logic [31:0] va, input logic w, input logic [31:0] pa,
                         input fault_code_t code);
        @(posedge mclk_in);
        req_valid_in <= 1'b1;
        req_in <= '{vaddr: va, write: w};
        do @(posedge mclk_in); while (req_ready_out !== 1'b1);
        req_valid_in <= 1'b0;
        do @(posedge mclk_in); while (rsp_valid_out !== 1'b1);
        chk(32'({rsp_out.fault, exception_out, rsp_out.code}), 32'({{2{code != FLT_NONE}}, code}));
        if (code == FLT_NONE) chk(rsp_out.paddr, pa);
    endtask
    task automatic results;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge mclk_in) if (++cyc == 20000) begin failures++; results(); end
    initial begin
        vat_mem_model_inst.mem[32'h1000] = 32'h8000_2000;
        vat_mem_model_inst.mem[32'h8000_200c] = 32'h8005_500c;
        vat_mem_model_inst.mem[32'h8000_2014] = 32'h8006_6004;
        vat_mem_model_inst.mem[32'h11fc] = 32'h8000_3000;
        vat_mem_model_inst.mem[32'h8000_3ffc] = 32'h8009_9008;
        vat_mem_model_inst.mem[32'h8000_2018] = 32'h8000_2080;
        repeat (5) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        rd(OFF_STATUS, 32'h4);
        rd(12'h020, 32'h0);
        chk(32'(err), 32'h1);
        apb(1'b1, OFF_SEG_DATA, 32'h0000_1010);
        rd(OFF_SEG_DATA, 32'h0000_1010);
        xlate(32'h0000_3abc, 1'b0, 32'h8005_5abc, FLT_NONE);
        chk(vat_mem_model_inst.mem[32'h8000_200c], 32'h8005_502c);
        vat_mem_model_inst.slow = 3;
        xlate(32'h0000_3004, 1'b1, 32'h8005_5004, FLT_NONE);
        chk(vat_mem_model_inst.mem[32'h8000_200c], 32'h8005_506c);
        xlate(32'h1fff_fabc, 1'b0, 32'h8009_9abc, FLT_NONE);
        xlate(32'h2000_0000, 1'b0, 32'h0, FLT_SEG_INV);
        xlate(32'h0000_5010, 1'b0, 32'h0, FLT_READ_DEN);
        xlate(32'h6abc, 1'b0, 32'h0, FLT_PAGE_INV);
        apb(1'b1, OFF_THREAD, 32'h3);
        xlate(32'h6abc, 1'b0, 32'h8005_5abc, FLT_NONE);
        apb(1'b1, OFF_CTRL, 32'h1);
        xlate(32'h0000_3abc, 1'b0, 32'h0, FLT_SEG_INV);
        apb(1'b1, OFF_POOL, 32'h6);
        thread_enter_in <= 1'b1;
        @(posedge mclk_in);
        thread_enter_in <= 1'b0;
        @(posedge mclk_in);
        chk(32'(thread_granted_out), 32'h1);
        rd(OFF_THREAD, 32'h1);
        thread_leave_in <= 1'b1;
        @(posedge mclk_in);
        thread_leave_in <= 1'b0;
        rd(OFF_POOL, 32'h6);
        results();
    end
endmodule
`default_nettype wire

//--- testbench/vat_assertions.sv
// Port checks for the translation block, bound to its top module
`default_nettype none
module vat_checker
    import vat_pkg::*;
(
    input wire logic      mclk_in,
    input wire logic      rst_b_in,
    input wire logic      req_valid_in,
    input wire core_req_t req_in,
    input wire logic      req_ready_out,
    input wire logic      rsp_valid_out,
    input wire core_rsp_t rsp_out,
    input wire logic      exception_out,
    input wire logic      mem_req_out,
    input wire mem_req_t  mem_out,
    input wire logic      mem_ack_in
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);
    core_req_t req_ff;
    wire       taken = req_valid_in && req_ready_out;
    // Last accepted request, so the answer can be tied to its cause
    always_ff @(posedge mclk_in) if (taken) req_ff <= req_in;
    AST_OFFSET: assert property (rsp_valid_out && !rsp_out.fault |->
        rsp_out.paddr[11:0] == req_ff.vaddr[11:0]) else $error("page offset lost");
    AST_ANSWER: assert property (taken |-> ##[2:600] rsp_valid_out)
        else $error("no answer to request");
    AST_BUSY: assert property (taken |=> !req_ready_out until rsp_valid_out)
        else $error("request taken while busy");
    AST_HOLD: assert property (mem_req_out && !mem_ack_in |=>
        mem_req_out && $stable(mem_out)) else $error("table access dropped");
    AST_ALIGN: assert property (mem_req_out |-> mem_out.addr[1:0] == 2'h0)
        else $error("table word not aligned");
    AST_REF: assert property (mem_req_out && mem_out.we |-> mem_out.wdata[PTW_REF_BIT])
        else $error("referenced mark missing");
    AST_MOD: assert property (mem_req_out && mem_out.we && req_ff.write |->
        mem_out.wdata[PTW_MOD_BIT]) else $error("modified mark missing");
    AST_EXC: assert property (exception_out == (rsp_valid_out && rsp_out.fault) &&
        (!rsp_out.fault || |rsp_out.code)) else $error("exception without fault answer");
    cover property (taken ##[2:600] exception_out);
    cover property (mem_req_out && mem_out.we && mem_ack_in);
    cover property (mem_req_out && !mem_ack_in ##1 mem_ack_in);
endmodule
bind virtual_address_translation vat_checker vat_checker_inst (.*);
`default_nettype wire

//--- testbench/vat_mem_model.sv
// Table memory that answers the walker after a settable wait
`default_nettype none
module vat_mem_model
    import vat_pkg::*;
(
    input  wire logic     mclk_in,
    input  wire logic     mem_req_in,
    input  wire mem_req_t mem_in,
    output logic          mem_ack_out = 1'b0,
    output logic [31:0]   mem_rdata_out = 32'h0
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] mem [logic [31:0]];
    int          slow = 0;
    int          waited = 0;
    always @(posedge mclk_in) begin
        mem_ack_out <= 1'b0;
        mem_rdata_out <= ~mem_rdata_out; // Stale data must not look valid
        if (mem_req_in && !mem_ack_out && waited < slow) begin
            waited <= waited + 1;
        end else if (mem_req_in && !mem_ack_out) begin
            waited <= 0;
            mem_ack_out <= 1'b1;
            mem_rdata_out <= mem.exists(mem_in.addr) ? mem[mem_in.addr] : 32'h0;
            if (mem_in.we) mem[mem_in.addr] = mem_in.wdata;
        end
    end
endmodule
`default_nettype wire

//--- verilog/translation_cache.sv
// Fully associative translation cache with round-robin replacement
`default_nettype none
module translation_cache
    import vat_pkg::*;
#(
    parameter int ENTRIES = 8
) (
    // Clock and reset
    input  wire logic                       mclk_in,
    input  wire logic                       rst_b_in,
    // Maintenance
    input  wire logic                       flush_in,
    // Lookup
    input  wire tc_key_t                    key_in,
    output logic                            hit_out,
    output logic [$clog2(ENTRIES)-1:0]      hit_idx_out,
    output tc_entry_t                       hit_entry_out,
    // Fill and status update
    input  wire logic                       fill_in,
    input  wire tc_entry_t                  fill_entry_in,
    input  wire logic                       upd_in,
    input  wire logic [$clog2(ENTRIES)-1:0] upd_idx_in,
    input  wire logic [31:0]                upd_word_in
);
    localparam int IW = $clog2(ENTRIES);

    tc_entry_t        ent_ff [ENTRIES];
    logic [ENTRIES-1:0] valid_ff;
    logic [IW-1:0]    rr_ff;
    logic [IW-1:0]    victim;
    logic             have_free;

    // Shared pages match any thread; unshared ones only their owner
    always_comb begin
        hit_out = 1'b0;
        hit_idx_out = '0;
        for (int i = 0; i < ENTRIES; i++) begin
            if (valid_ff[i] && ent_ff[i].vpn == key_in.vpn && ent_ff[i].psi == key_in.psi &&
                (!ent_ff[i].unshared || ent_ff[i].thread_number == key_in.thread_number)) begin
                hit_out = 1'b1;
                hit_idx_out = IW'(i);
            end
        end
    end

    assign hit_entry_out = ent_ff[hit_idx_out];

    always_comb begin
        have_free = 1'b0;
        victim = rr_ff;
        for (int i = ENTRIES - 1; i >= 0; i--) begin
            if (!valid_ff[i]) begin
                have_free = 1'b1;
                victim = IW'(i);
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            valid_ff <= '0;
            rr_ff <= '0;
        end else if (flush_in) begin
            valid_ff <= '0;
        end else if (fill_in) begin
            valid_ff[victim] <= 1'b1;
            if (!have_free) begin
                rr_ff <= rr_ff + 1'b1;
            end
        end
    end

    // Payload carries no reset; valid bits guard it
    always_ff @(posedge mclk_in) begin
        if (fill_in) begin
            ent_ff[victim] <= fill_entry_in;
        end else if (upd_in) begin
            ent_ff[upd_idx_in].word <= upd_word_in;
        end
    end
endmodule
`default_nettype wire

//--- verilog/vat_pkg.sv
// Constants, field layouts and carrier types for the address translation block
`default_nettype none
package vat_pkg;
    // Address geometry
    localparam int SEG_SHIFT       = 29;   // 512 Mbyte segment
    localparam int PAGE_SHIFT      = 12;   // 4 Kbyte page
    localparam int WORD_SHIFT      = 2;    // 4-byte table word
    localparam int SEGS_PER_SET    = 8;
    localparam int THREAD_W        = 5;
    localparam int THREAD_W_REDUCED = 3;
    localparam int PSI_MAX_W       = 5;
    // Register byte offsets
    localparam logic [11:0] OFF_CTRL     = 12'h000;
    localparam logic [11:0] OFF_THREAD   = 12'h004;
    localparam logic [11:0] OFF_POOL     = 12'h008;
    localparam logic [11:0] OFF_SEG_SEL  = 12'h00c;
    localparam logic [11:0] OFF_SEG_DATA = 12'h010;
    localparam logic [11:0] OFF_FAULT    = 12'h014;
    localparam logic [11:0] OFF_FAULT_VA = 12'h018;
    localparam logic [11:0] OFF_STATUS   = 12'h01c;
    // Control register fields
    localparam int CTRL_FLUSH_BIT  = 8;
    // Status register fields
    localparam int STAT_BUSY_BIT   = 0;
    localparam int STAT_ACTIVE_BIT = 1;
    localparam int STAT_EMPTY_BIT  = 2;
    // Segment descriptor fields
    localparam int SD_VALID_BIT    = 4;
    localparam int SD_BASE_LSB     = 9;
    // Page table word fields
    localparam int PTW_VALID_BIT   = 31;
    localparam int PTW_FRAME_LSB   = 12;
    localparam int PTW_UNSHARED_BIT = 7;
    localparam int PTW_MOD_BIT     = 6;
    localparam int PTW_REF_BIT     = 5;
    localparam int PTW_RD_BIT      = 3;
    localparam int PTW_WR_BIT      = 2;
    // Reset values
    localparam logic [31:0] SEG_DESC_RST = 32'h0000_0000;
    localparam logic [31:0] POOL_RST     = 32'h0000_0000;
    localparam logic [4:0]  THREAD_RST   = 5'h00;
    localparam logic [4:0]  PSI_RST      = 5'h00;

    typedef enum logic [3:0] {
        FLT_NONE      = 4'h0,
        FLT_SEG_INV   = 4'h1,
        FLT_PAGE_INV  = 4'h2,
        FLT_READ_DEN  = 4'h3,
        FLT_WRITE_DEN = 4'h4
    } fault_code_t;

    typedef struct packed {
        logic [31:0] vaddr;
        logic        write;
    } core_req_t;

    typedef struct packed {
        logic [31:0] paddr;
        logic        fault;
        fault_code_t code;
    } core_rsp_t;

    typedef struct packed {
        logic        we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mem_req_t;

    typedef struct packed {
        logic [19:0] vpn;
        logic [4:0]  psi;
        logic [4:0]  thread_number;
    } tc_key_t;

    typedef struct packed {
        logic [19:0] vpn;
        logic [4:0]  psi;
        logic [4:0]  thread_number;
        logic        unshared;
        logic [31:0] word;
        logic [31:0] addr;
    } tc_entry_t;
endpackage
`default_nettype wire

//--- verilog/virtual_address_translation.sv
// Virtual-to-physical translation: table walker, thread pool and register file
// Function
// - A segment is a contiguous 512 Mbyte block of virtual addresses.
// - Each segment descriptor is a 32-bit register that starts the translation.
// - Translation granularity is a 4 Kbyte page, contiguous in both spaces.
// - Page tables hold 4-byte words, page aligned, within one page frame.
// - Page table words are 32-bit aligned; status bits give residency and protection.
// - Any valid read or write sets the referenced indication of the frame.
// - Only a valid write sets the modified indication of the frame.
// - Hardware alone keeps the cache of recent translations, invisible to programs.
// - Pages are mapped at run time by walking a tree of lookup tables.
// - One process set index per CPU selects the active segment descriptors.
// - Process set index is 3 bits in one variant, 5 bits otherwise.
// - A 5-bit thread number register distinguishes up to 32 threads.
// - Reduced variant honours only thread number bits 2..0, ignoring 4..3.
// - A thread level table of 32 entries is indexed by the thread number.
// - Shared pages map one virtual address of all threads to one location.
// - Unshared pages map one virtual address to a location per thread.
// - Hardware allocates and releases thread numbers from the software pool.
// - Invalid segment raises an exception, context save, error code loaded.
// - Read of a read-protected page raises an exception and loads an error code.
`default_nettype none
module virtual_address_translation
    import vat_pkg::*;
#(
    parameter int PSI_W           = 5,
    parameter bit REDUCED_THREADS = 1'b0,
    parameter int TC_ENTRIES      = 8
) (
    // Clock and reset
    input  wire logic        mclk_in,
    input  wire logic        rst_b_in,
    // APB slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic [31:0]      prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // Core translation request
    input  wire logic        req_valid_in,
    input  wire core_req_t   req_in,
    output logic             req_ready_out,
    output logic             rsp_valid_out,
    output core_rsp_t        rsp_out,
    output logic             exception_out,
    // Thread entry and exit
    input  wire logic        thread_enter_in,
    input  wire logic        thread_leave_in,
    output logic             thread_granted_out,
    // Table memory port
    output logic             mem_req_out,
    output mem_req_t         mem_out,
    input  wire logic        mem_ack_in,
    input  wire logic [31:0] mem_rdata_in
);
    localparam int NDESC   = (2 ** PSI_W) * SEGS_PER_SET;
    localparam int DIDX_W  = PSI_W + 3;
    localparam int TC_IW   = $clog2(TC_ENTRIES);

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_LOOK = 3'h1,
        ST_L1   = 3'h2,
        ST_L2   = 3'h3,
        ST_THR  = 3'h4,
        ST_MARK = 3'h5,
        ST_RESP = 3'h6
    } walk_state_t;

    function automatic logic [4:0] first_free(input logic [31:0] mask);
        logic [4:0] idx;
        idx = 5'h00;
        for (int i = 31; i >= 0; i--) begin
            if (mask[i]) begin
                idx = 5'(i);
            end
        end
        return idx;
    endfunction

    // Registers
    walk_state_t         state_ff;
    walk_state_t         nxt_state;
    core_req_t           req_ff;
    core_rsp_t           rsp_ff;
    core_rsp_t           nxt_rsp;
    mem_req_t            mem_ff;
    mem_req_t            nxt_mem;
    fault_code_t         fault_code_address_reg_ff;
    fault_code_t         nxt_fault_code;
    logic [31:0]         fault_va_ff;
    logic [31:0]         nxt_fault_va;
    logic [PSI_W-1:0]    process_set_index_ff;
    logic [4:0]          thread_number_ff;
    logic                thread_active_ff;
    logic [31:0]         free_pool_ff;
    logic [DIDX_W-1:0]   seg_sel_ff;
    logic [31:0]         segment_descriptor_ff [NDESC];
    logic [31:0]         prdata_ff;
    logic                flush_ff;

    // APB decode
    wire logic        apb_setup  = psel_in & ~penable_in;
    wire logic        apb_access = psel_in & penable_in;
    wire logic        addr_ok    = (paddr_in[11:5] == 7'h00) && (paddr_in[1:0] == 2'b00);
    wire logic        apb_wr     = apb_access & pwrite_in & addr_ok;
    wire logic        wr_ctrl    = apb_wr && paddr_in == OFF_CTRL;
    wire logic        wr_thread  = apb_wr && paddr_in == OFF_THREAD;
    wire logic        wr_pool    = apb_wr && paddr_in == OFF_POOL;
    wire logic        wr_sel     = apb_wr && paddr_in == OFF_SEG_SEL;
    wire logic        wr_seg     = apb_wr && paddr_in == OFF_SEG_DATA;
    wire logic        pool_empty = (free_pool_ff == 32'h0000_0000);
    wire logic        do_enter   = thread_enter_in & ~thread_active_ff & ~pool_empty;
    wire logic        do_leave   = thread_leave_in & thread_active_ff;
    wire logic [4:0]  grant_tid  = first_free(free_pool_ff);

    assign pready_out  = 1'b1;
    assign pslverr_out = apb_access & ~addr_ok;
    assign prdata_out  = prdata_ff;

    // Thread number as seen by the walker
    wire logic [4:0] tid_eff = REDUCED_THREADS ?
        {2'b00, thread_number_ff[THREAD_W_REDUCED-1:0]} : thread_number_ff;
    wire logic [4:0] psi_key = 5'(process_set_index_ff);

    // Current reference
    wire logic [2:0]  seg_num  = req_ff.vaddr[31:SEG_SHIFT];
    wire logic [6:0]  l1_idx   = req_ff.vaddr[SEG_SHIFT-1:22];
    wire logic [9:0]  l2_idx   = req_ff.vaddr[21:PAGE_SHIFT];
    wire logic [31:0] seg_word = segment_descriptor_ff[{process_set_index_ff, seg_num}];

    // Cache
    tc_key_t             tc_key;
    logic                tc_hit;
    logic [TC_IW-1:0]    tc_idx;
    tc_entry_t           tc_entry;
    tc_entry_t           fill_entry;
    logic                fill_en;
    logic                upd_en;

    assign tc_key = '{vpn: req_ff.vaddr[31:PAGE_SHIFT], psi: psi_key, thread_number: tid_eff};

    wire logic [31:0] hit_word  = tc_entry.word;
    wire logic        perm_ok   = req_ff.write ? hit_word[PTW_WR_BIT] : hit_word[PTW_RD_BIT];
    wire logic        need_mark = ~hit_word[PTW_REF_BIT] | (req_ff.write & ~hit_word[PTW_MOD_BIT]);
    wire logic [31:0] ref_mask  = 32'h1 << PTW_REF_BIT;
    wire logic [31:0] mod_mask  = req_ff.write ? (32'h1 << PTW_MOD_BIT) : 32'h0;
    wire logic [31:0] marked    = hit_word | ref_mask | mod_mask;
    wire logic        in_thr    = (state_ff == ST_THR);

    // Unshared entries are tagged with their thread, shared ones are not
    assign fill_entry = '{vpn: req_ff.vaddr[31:PAGE_SHIFT], psi: psi_key,
                          thread_number: in_thr ? tid_eff : 5'h00, unshared: in_thr,
                          word: mem_rdata_in, addr: mem_ff.addr};

    translation_cache #(
        .ENTRIES       (TC_ENTRIES)
    ) u_cache (
        .mclk_in       (mclk_in),
        .rst_b_in      (rst_b_in),
        .flush_in      (flush_ff),
        .key_in        (tc_key),
        .hit_out       (tc_hit),
        .hit_idx_out   (tc_idx),
        .hit_entry_out (tc_entry),
        .fill_in       (fill_en),
        .fill_entry_in (fill_entry),
        .upd_in        (upd_en),
        .upd_idx_in    (tc_idx),
        .upd_word_in   (mem_ff.wdata)
    );

    // Walker
    logic        raise;
    fault_code_t raise_code;

    always_comb begin
        nxt_state = state_ff;
        nxt_mem = mem_ff;
        nxt_rsp = rsp_ff;
        nxt_fault_code = fault_code_address_reg_ff;
        nxt_fault_va = fault_va_ff;
        fill_en = 1'b0;
        upd_en = 1'b0;
        raise = 1'b0;
        raise_code = FLT_NONE;
        case (state_ff)
            ST_IDLE: begin
                if (req_valid_in) begin
                    nxt_state = ST_LOOK;
                end
            end
            ST_LOOK: begin
                if (tc_hit) begin
                    if (!perm_ok) begin
                        raise = 1'b1;
                        raise_code = req_ff.write ? FLT_WRITE_DEN : FLT_READ_DEN;
                    end else if (need_mark) begin
                        nxt_mem = '{we: 1'b1, addr: tc_entry.addr, wdata: marked};
                        nxt_state = ST_MARK;
                    end else begin
                        nxt_rsp = '{paddr: {hit_word[31:PTW_FRAME_LSB],
                                    req_ff.vaddr[PAGE_SHIFT-1:0]},
                                    fault: 1'b0, code: FLT_NONE};
                        nxt_state = ST_RESP;
                    end
                end else if (!seg_word[SD_VALID_BIT]) begin
                    raise = 1'b1;
                    raise_code = FLT_SEG_INV;
                end else begin
                    nxt_mem = '{we: 1'b0, addr: {seg_word[31:SD_BASE_LSB], l1_idx, 2'b00},
                                wdata: 32'h0};
                    nxt_state = ST_L1;
                end
            end
            ST_L1: begin
                if (mem_ack_in) begin
                    if (!mem_rdata_in[PTW_VALID_BIT]) begin
                        raise = 1'b1;
                        raise_code = FLT_PAGE_INV;
                    end else begin
                        nxt_mem.addr = {mem_rdata_in[31:PTW_FRAME_LSB], l2_idx, 2'b00};
                        nxt_state = ST_L2;
                    end
                end
            end
            ST_L2: begin
                if (mem_ack_in) begin
                    if (!mem_rdata_in[PTW_VALID_BIT]) begin
                        raise = 1'b1;
                        raise_code = FLT_PAGE_INV;
                    end else if (mem_rdata_in[PTW_UNSHARED_BIT]) begin
                        nxt_mem.addr = {mem_rdata_in[31:PTW_FRAME_LSB], 5'h00, tid_eff,
                                        2'b00};
                        nxt_state = ST_THR;
                    end else begin
                        fill_en = 1'b1;
                        nxt_state = ST_LOOK;
                    end
                end
            end
            ST_THR: begin
                if (mem_ack_in) begin
                    if (!mem_rdata_in[PTW_VALID_BIT]) begin
                        raise = 1'b1;
                        raise_code = FLT_PAGE_INV;
                    end else begin
                        fill_en = 1'b1;
                        nxt_state = ST_LOOK;
                    end
                end
            end
            ST_MARK: begin
                if (mem_ack_in) begin
                    upd_en = 1'b1;
                    nxt_rsp = '{paddr: {hit_word[31:PTW_FRAME_LSB],
                                req_ff.vaddr[PAGE_SHIFT-1:0]},
                                fault: 1'b0, code: FLT_NONE};
                    nxt_state = ST_RESP;
                end
            end
            ST_RESP: begin
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
        if (raise) begin
            nxt_rsp = '{paddr: 32'h0, fault: 1'b1, code: raise_code};
            nxt_fault_code = raise_code;
            nxt_fault_va = req_ff.vaddr;
            nxt_state = ST_RESP;
        end
    end

    // Walker outputs; the core saves its context on the exception pulse
    assign req_ready_out = (state_ff == ST_IDLE);
    assign rsp_valid_out = (state_ff == ST_RESP);
    assign exception_out = (state_ff == ST_RESP) & rsp_ff.fault;
    assign rsp_out       = rsp_ff;
    assign mem_req_out   = (state_ff == ST_L1) | (state_ff == ST_L2) |
                           (state_ff == ST_THR) | (state_ff == ST_MARK);
    assign mem_out       = mem_ff;

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_ff <= ST_IDLE;
            req_ff <= '0;
            rsp_ff <= '0;
            mem_ff <= '0;
            fault_code_address_reg_ff <= FLT_NONE;
            fault_va_ff <= 32'h0;
        end else begin
            state_ff <= nxt_state;
            if (req_valid_in && state_ff == ST_IDLE) begin
                req_ff <= req_in;
            end
            rsp_ff <= nxt_rsp;
            mem_ff <= nxt_mem;
            fault_code_address_reg_ff <= nxt_fault_code;
            fault_va_ff <= nxt_fault_va;
        end
    end

    // Thread pool: a release in the same cycle as a pool write is kept
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            thread_number_ff <= THREAD_RST;
            thread_active_ff <= 1'b0;
            free_pool_ff <= POOL_RST;
            thread_granted_out <= 1'b0;
        end else begin
            thread_granted_out <= do_enter;
            if (do_enter) begin
                thread_number_ff <= grant_tid;
                thread_active_ff <= 1'b1;
            end else if (do_leave) begin
                thread_active_ff <= 1'b0;
            end else if (wr_thread) begin
                thread_number_ff <= pwdata_in[4:0];
            end
            if (wr_pool) begin
                free_pool_ff <= pwdata_in | (do_leave ? (32'h1 << thread_number_ff) : 32'h0);
            end else if (do_enter) begin
                free_pool_ff <= free_pool_ff & ~(32'h1 << grant_tid);
            end else if (do_leave) begin
                free_pool_ff <= free_pool_ff | (32'h1 << thread_number_ff);
            end
        end
    end

    // Descriptor store and control; a descriptor write drops stale translations
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            process_set_index_ff <= PSI_W'(PSI_RST);
            seg_sel_ff <= '0;
            flush_ff <= 1'b0;
            for (int i = 0; i < NDESC; i++) begin
                segment_descriptor_ff[i] <= SEG_DESC_RST;
            end
        end else begin
            flush_ff <= (wr_ctrl & pwdata_in[CTRL_FLUSH_BIT]) | wr_seg;
            if (wr_ctrl) begin
                process_set_index_ff <= pwdata_in[PSI_W-1:0];
            end
            if (wr_sel) begin
                seg_sel_ff <= pwdata_in[DIDX_W-1:0];
            end
            if (wr_seg) begin
                segment_descriptor_ff[seg_sel_ff] <= pwdata_in;
            end
        end
    end

    // Read data is captured in the setup phase, ready in the access phase
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            prdata_ff <= 32'h0;
        end else if (apb_setup && !pwrite_in) begin
            case (paddr_in)
                OFF_CTRL:     prdata_ff <= 32'(process_set_index_ff);
                OFF_THREAD:   prdata_ff <= {27'h0, tid_eff};
                OFF_POOL:     prdata_ff <= free_pool_ff;
                OFF_SEG_SEL:  prdata_ff <= 32'(seg_sel_ff);
                OFF_SEG_DATA: prdata_ff <= segment_descriptor_ff[seg_sel_ff];
                OFF_FAULT:    prdata_ff <= {28'h0, fault_code_address_reg_ff};
                OFF_FAULT_VA: prdata_ff <= fault_va_ff;
                OFF_STATUS:   prdata_ff <= {29'h0, pool_empty, thread_active_ff,
                                            state_ff != ST_IDLE};
                default:      prdata_ff <= 32'h0;
            endcase
        end
    end
endmodule
`default_nettype wire
